// *** rtl/iac_defs.svh ***
`ifndef IAC_DEFS_SVH
`define IAC_DEFS_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define IAC_OFS_CTRL 5'h0_0
`define IAC_OFS_STATUS 5'h0_4
`define IAC_OFS_ACC 5'h0_8
`define IAC_OFS_MBUF 5'h0_C
`define IAC_OFS_MADDR 5'h1_0
// ****************************************
// Control register fields
// ****************************************
`define IAC_CTRL_START 0
`define IAC_CTRL_HALT 1
`define IAC_CTRL_CONGATE 2
`define IAC_CTRL_ADDOP 3
`define IAC_CTRL_IDXCLS 4
`define IAC_CTRL_IRQ 5
`define IAC_CTRL_EXEC2 6
`define IAC_CTRL_ALTSW 7
`define IAC_CTRL_PRESET 8
`define IAC_CTRL_PWRCLR 9
`define IAC_CTRL_RST 10'h0_00
// ****************************************
// Status register fields
// ****************************************
`define IAC_STAT_OVF 9
`define IAC_STAT_AUX 10
// ****************************************
// Timing
// ****************************************
`define IAC_CLK_MHZ 200
`define IAC_TP3_NS 350
`define IAC_TP4_NS 300
`define IAC_TP5_NS 400
`define IAC_TP3_CYC ((`IAC_TP3_NS * `IAC_CLK_MHZ) / 1000)
`define IAC_TP4_CYC ((`IAC_TP4_NS * `IAC_CLK_MHZ) / 1000)
`define IAC_TP5_CYC ((`IAC_TP5_NS * `IAC_CLK_MHZ) / 1000)
`endif

// *** rtl/iac_pkg.sv ***
package iac_pkg;
  typedef enum logic [1:0] {MS_DEFER, MS_EXECUTE, MS_FETCH} iac_major_t;
  typedef logic [11:0] iac_word_t;
endpackage

// *** rtl/iac_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iac_defs.svh"
// What this block does
// - Defer TS3 gates memory halves onto bus
// - Pulse 3 loads buffer with memory plus carry
// - Pulse 3 moves state 3 to 4
// - Pulse 4 sets marker on buffer bit 00
// - Pulse 4 sets state 5
// - Pulse 5 comes 400 ns after 4
// - Pulse 5 clocks run, stays set unless halted
// - Pulse 5 moves state 5 to 1
// - Cycle done set at major state end
// - Time state 1 enables buffer bits 5-11
// - Index class also enables bits 2-4
// - Pulse 1 needs run, idle, done, and a major state other than fetch
// - Pulse 1 loads address from bus
// - Pulse 1 moves state 1 to 2
// - Memory strobe gives pulse 2, clears idle
// - Pulse 3 comes 350 ns after 2
// - Memory done sets idle
// - Add select enables buffer, accumulator into adder
// - Pulse 4 comes 300 ns after 3
// - Pulse 4 loads accumulator with sum
// - Carry out of bit 00 sets overflow
// - Power clear selects legacy mode; preset loads the mode from the alternate switch
// - Pulse 1 with console gate starts memory
module iac_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic memReadPulse,
  input wire logic memDone,
  input wire iac_pkg::iac_word_t memData,
  output logic memStart,
  output iac_pkg::iac_word_t memAddress,
  output iac_pkg::iac_word_t regBus,
  output logic [4:0] timingPulse,
  output logic [4:0] timeState,
  output logic adderSelect
);
  import iac_pkg::*;

  localparam int SYNC_W = 14;
  localparam logic [6:0] TP3_CYC = 7'(`IAC_TP3_CYC);
  localparam logic [6:0] TP4_CYC = 7'(`IAC_TP4_CYC);
  localparam logic [6:0] TP5_CYC = 7'(`IAC_TP5_CYC);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // A change counts only once stages two and three agree
  logic [SYNC_W-1:0] syncA_q, syncB_q, syncC_q, pin_q, pinPrev_q;
  logic [SYNC_W-1:0] pin_d;
  assign pin_d = (syncB_q & syncC_q) | (pin_q & (syncB_q | syncC_q));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      pin_q <= '0;
      pinPrev_q <= '0;
    end else if (clkEn) begin
      syncA_q <= {memDone, memReadPulse, memData};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      pin_q <= pin_d;
      pinPrev_q <= pin_q;
    end
  end
  wire iac_word_t memWord = pin_q[11:0];
  wire readEdge = pin_q[12] & ~pinPrev_q[12];
  wire doneEdge = pin_q[13] & ~pinPrev_q[13];

  // ****************************************
  // Sequencer state
  // ****************************************
  logic [4:0] ts_q;
  iac_major_t major_q;
  logic run_q, memIdle_q, cycleDone_q, overflow_q, auxMark_q, altMode_q;
  logic [6:0] cnt_q;
  iac_word_t ac_q, mb_q, ma_q;
  logic [9:0] ctrl_q;

  wire conGate = ctrl_q[`IAC_CTRL_CONGATE];
  wire addOp = ctrl_q[`IAC_CTRL_ADDOP];
  wire idxClass = ctrl_q[`IAC_CTRL_IDXCLS];
  wire irqState = ctrl_q[`IAC_CTRL_IRQ];
  wire secondExec = ctrl_q[`IAC_CTRL_EXEC2];
  wire isDefer = major_q == MS_DEFER;
  wire isExec = major_q == MS_EXECUTE;
  wire cntZero = cnt_q == 7'h0_0;

  // Timing pulses, each one clock long and gated by the enable
  wire tp1 = clkEn & ts_q[0] & run_q & memIdle_q & cycleDone_q & ~(major_q == MS_FETCH);
  wire tp2 = clkEn & ts_q[1] & readEdge;
  wire tp3 = clkEn & ts_q[2] & cntZero;
  wire tp4 = clkEn & ts_q[3] & cntZero;
  wire tp5 = clkEn & ts_q[4] & cntZero;

  // ****************************************
  // Register bus and adder
  // ****************************************
  wire memHalves = isDefer & ts_q[2] & conGate & ~irqState;
  // Major state moves at pulse 5, so time state 1 after defer already reads execute
  wire enMbLow = ts_q[0] & isExec;
  wire enMbMid = enMbLow & idxClass;
  wire addSel = isExec & addOp;
  wire addPath = addSel & ts_q[3];
  wire [12:0] sum = {1'b0, ac_q} + {1'b0, mb_q};
  wire carryIns = isDefer & idxClass;
  wire iac_word_t mbNext = memWord + {11'h0_00, carryIns};
  wire iac_word_t busVal =
    memHalves ? memWord :
    addPath ? sum[11:0] :
    enMbLow ? {2'b00, mb_q[9:7] & {3{enMbMid}}, mb_q[6:0]} :
    12'h0_00;

  // ****************************************
  // Avalon slave
  // ****************************************
  // Fixed one-cycle answer; the wait state keeps the decode off the request path
  logic waitReq_q;
  logic [31:0] rdata_q;
  wire acc = (avs_read | avs_write) & waitReq_q & clkEn;
  wire wrTake = avs_write & ~waitReq_q & clkEn;
  wire selCtrl = avs_address == `IAC_OFS_CTRL;
  wire selStat = avs_address == `IAC_OFS_STATUS;
  wire selAcc = avs_address == `IAC_OFS_ACC;
  wire selMbuf = avs_address == `IAC_OFS_MBUF;
  wire selMaddr = avs_address == `IAC_OFS_MADDR;
  wire [11:0] statusWord = {altMode_q, auxMark_q, overflow_q,
    cycleDone_q, memIdle_q, run_q, isExec, ts_q};
  wire [31:0] rdMux =
    selCtrl ? {22'h00_0000, ctrl_q} :
    selStat ? {20'h0_0000, statusWord} :
    selAcc ? {20'h0_0000, ac_q} :
    selMbuf ? {20'h0_0000, mb_q} :
    selMaddr ? {20'h0_0000, ma_q} :
    32'h0000_0000;
  wire ctrlWr = wrTake & selCtrl;
  wire startReq = ctrlWr & avs_writedata[`IAC_CTRL_START] & ~run_q;
  wire presetReq = ctrlWr & avs_writedata[`IAC_CTRL_PRESET];
  wire pwrClr = ctrlWr & avs_writedata[`IAC_CTRL_PWRCLR];
  wire ovfClr = wrTake & selStat & avs_writedata[`IAC_STAT_OVF];
  wire auxClr = wrTake & selStat & avs_writedata[`IAC_STAT_AUX];
  wire accWr = wrTake & selAcc & ~run_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitReq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clkEn) begin
      waitReq_q <= ~acc;
      if (acc) begin
        rdata_q <= rdMux;
      end
    end
  end

  // Start, preset and power-clear bits self-clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= `IAC_CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_q <= {3'b000, avs_writedata[6:1], 1'b0};
      ctrl_q[`IAC_CTRL_ALTSW] <= avs_writedata[`IAC_CTRL_ALTSW];
    end
  end

  // ****************************************
  // Time states and major state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ts_q <= 5'b0_0001;
      major_q <= MS_FETCH;
      cnt_q <= 7'h0_0;
    end else if (clkEn) begin
      if (startReq && !run_q) begin
        ts_q <= 5'b0_0001;
        major_q <= MS_DEFER;
      end else if (tp1) begin
        ts_q <= 5'b0_0010;
      end else if (tp2) begin
        ts_q <= 5'b0_0100;
        cnt_q <= TP3_CYC - 7'h0_1;
      end else if (tp3) begin
        ts_q <= 5'b0_1000;
        cnt_q <= TP4_CYC - 7'h0_1;
      end else if (tp4) begin
        ts_q <= 5'b1_0000;
        cnt_q <= TP5_CYC - 7'h0_1;
      end else if (tp5) begin
        ts_q <= 5'b0_0001;
        if (isDefer) begin
          major_q <= MS_EXECUTE;
        end else if (isExec) begin
          major_q <= MS_FETCH;
        end
      end else if (!cntZero) begin
        cnt_q <= cnt_q - 7'h0_1;
      end
    end
  end

  // ****************************************
  // Control flip-flops
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      cycleDone_q <= 1'b0;
      memIdle_q <= 1'b1;
    end else if (clkEn) begin
      if (startReq) begin
        run_q <= 1'b1;
      end else if (tp5) begin
        run_q <= ~ctrl_q[`IAC_CTRL_HALT];
      end
      if (startReq || tp5) begin
        cycleDone_q <= 1'b1;
      end else if (tp1) begin
        cycleDone_q <= 1'b0;
      end
      if (doneEdge) begin
        memIdle_q <= 1'b1;
      end else if (tp2) begin
        memIdle_q <= 1'b0;
      end
    end
  end

  // Overflow and marker sets win over a software clear in the same cycle; power clear wins over preset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overflow_q <= 1'b0;
      auxMark_q <= 1'b0;
      altMode_q <= 1'b0;
    end else if (clkEn) begin
      if (tp4 && addSel && sum[12]) begin
        overflow_q <= 1'b1;
      end else if (ovfClr) begin
        overflow_q <= 1'b0;
      end
      if (tp4 && isDefer && altMode_q && mb_q[11]) begin
        auxMark_q <= 1'b1;
      end else if (auxClr) begin
        auxMark_q <= 1'b0;
      end
      if (pwrClr) begin
        altMode_q <= 1'b0;
      end else if (presetReq) begin
        altMode_q <= avs_writedata[`IAC_CTRL_ALTSW];
      end
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ac_q <= 12'h0_00;
      mb_q <= 12'h0_00;
      ma_q <= 12'h0_00;
    end else if (clkEn) begin
      if (tp3 && !secondExec) begin
        mb_q <= mbNext;
      end
      if (tp4 && addSel) begin
        ac_q <= sum[11:0];
      end else if (accWr) begin
        ac_q <= avs_writedata[11:0];
      end
      if (tp1) begin
        ma_q <= busVal;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memStart <= 1'b0;
      regBus <= 12'h0_00;
      timingPulse <= 5'b0_0000;
      timeState <= 5'b0_0001;
      adderSelect <= 1'b0;
    end else if (clkEn) begin
      memStart <= tp1 & conGate;
      regBus <= busVal;
      timingPulse <= {tp5, tp4, tp3, tp2, tp1};
      timeState <= ts_q;
      adderSelect <= addSel;
    end
  end
  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdata_q;
  assign memAddress = ma_q;

  // ****************************************
  // Checks
  // ****************************************
  logic [6:0] gap_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap_q <= 7'h0_0;
    end else if (tp2 || tp3 || tp4) begin
      gap_q <= 7'h0_1;
    end else if (clkEn && gap_q != 7'h7_F) begin
      gap_q <= gap_q + 7'h0_1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ts_onehot: assert property ($onehot(ts_q))
    else $error("time states not one-hot");
  a_tp1_gate: assert property (tp1 |-> run_q && memIdle_q && cycleDone_q)
    else $error("pulse 1 without run, idle and done");
  a_tp1_addr: assert property (tp1 |=> ma_q == $past(busVal) && ts_q == 5'b0_0010)
    else $error("pulse 1 did not load address");
  a_tp1_memstart: assert property (tp1 && conGate |=> memStart)
    else $error("memory start missing");
  a_tp2_idle: assert property (tp2 |=> !memIdle_q || $past(doneEdge))
    else $error("strobe did not clear idle");
  a_tp3_delay: assert property (tp3 |-> gap_q == TP3_CYC)
    else $error("pulse 3 spacing wrong");
  a_tp3_mbload: assert property (tp3 && !secondExec |=> mb_q == $past(mbNext) && ts_q[3])
    else $error("buffer load at pulse 3 wrong");
  a_tp5_delay: assert property (tp5 |-> gap_q == TP5_CYC)
    else $error("pulse 5 spacing wrong");
  a_tp4_sum: assert property (tp4 && addSel |=> ac_q == $past(sum[11:0]) && overflow_q == ($past(overflow_q) | $past(sum[12])))
    else $error("accumulator sum wrong");
  a_tp5_cycle: assert property (tp5 |=> ts_q[0] && cycleDone_q)
    else $error("pulse 5 did not recycle");
  a_ts3_halves: assert property (isDefer && ts_q[2] && conGate && !irqState |-> busVal == memWord)
    else $error("memory halves not on bus");
  a_tp3_advance: assert property (tp3 |=> ts_q == 5'b0_1000)
    else $error("pulse 3 did not enter state 4");
  a_tp4_delay: assert property (tp4 |-> gap_q == TP4_CYC)
    else $error("pulse 4 spacing wrong");
  a_tp4_ts5: assert property (tp4 |=> ts_q == 5'b1_0000)
    else $error("pulse 4 did not enter state 5");
  a_tp4_aux: assert property (tp4 && isDefer && altMode_q && mb_q[11] |=> auxMark_q)
    else $error("marker not set");
  a_tp5_run: assert property (tp5 |=> run_q == !$past(ctrl_q[`IAC_CTRL_HALT]))
    else $error("run not clocked at pulse 5");
  a_defer_exec: assert property (tp5 && isDefer |=> isExec)
    else $error("execute not entered after defer");
  a_done_idle: assert property (doneEdge && clkEn |=> memIdle_q)
    else $error("memory done did not set idle");
  a_ovf_set: assert property (tp4 && addSel && sum[12] |=> overflow_q)
    else $error("overflow not set on carry");
  a_pwr_legacy: assert property (pwrClr |=> !altMode_q)
    else $error("power clear left alternate mode");
  a_ts1_bus: assert property (ts_q[0] && isExec |-> busVal[11:10] == 2'b00 && busVal[6:0] == mb_q[6:0] &&
    busVal[9:7] == (idxClass ? mb_q[9:7] : 3'b000))
    else $error("time state 1 bus enables wrong");

  c_defer_done: cover property (tp5 && isDefer);
  c_exec_add: cover property (tp4 && addSel);
  c_overflow: cover property (tp4 && addSel && sum[12]);
  c_aux_mark: cover property (tp4 && isDefer && altMode_q && mb_q[11]);
  c_alt_preset: cover property (presetReq && avs_writedata[`IAC_CTRL_ALTSW]);
endmodule // iac_sequencer
`default_nettype wire

// *** tb/iac_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Core memory far side
// ****
module iac_mem_model #(
  parameter int StrobeDly = 100
) (
  input wire logic clk,
  input wire logic memStart,
  input wire iac_pkg::iac_word_t nextWord,
  output logic memReadPulse,
  output logic memDone,
  output iac_pkg::iac_word_t memData
);
  import iac_pkg::*;
  initial begin
    memReadPulse = 1'b0;
    memDone = 1'b0;
    memData = '0;
    forever begin
      @(posedge clk);
      if (memStart === 1'b1) begin
        memData <= nextWord;
        repeat (StrobeDly) @(posedge clk);
        memReadPulse <= 1'b1;
        repeat (4) @(posedge clk);
        memReadPulse <= 1'b0;
        // Data held past the end of time state 3, then scrambled
        repeat (90) @(posedge clk);
        memDone <= 1'b1;
        memData <= ~memData;
        repeat (4) @(posedge clk);
        memDone <= 1'b0;
      end
    end
  end
endmodule // iac_mem_model
`default_nettype wire

// *** tb/indexed_add_cycle_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iac_defs.svh"
// ****
// Bench
// ****
module indexed_add_cycle_sequencer_tb;
  import iac_pkg::*;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, memReadPulse, memDone, memStart, adderSelect;
  logic [4:0] avs_address, timingPulse, timeState;
  logic [31:0] avs_writedata, avs_readdata, q;
  iac_word_t memData, memAddress, regBus, nextWord;
  iac_word_t expW1, expSum;
  logic clkEn;
  int failures = 0, comparisons = 0, cyc = 0, tp5n = 0, mcount = 0;
  int t2, t3, t4;
  iac_sequencer u_iac_sequencer (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .memReadPulse(memReadPulse), .memDone(memDone), .memData(memData),
    .memStart(memStart), .memAddress(memAddress), .regBus(regBus), .timingPulse(timingPulse),
    .timeState(timeState), .adderSelect(adderSelect));
  iac_mem_model u_iac_mem_model (.clk(clk), .memStart(memStart), .nextWord(nextWord),
    .memReadPulse(memReadPulse), .memDone(memDone), .memData(memData));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Delay lines are fixed clock counts
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timingPulse[1] === 1'b1) t2 <= cyc;
    if (timingPulse[2] === 1'b1) begin
      t3 <= cyc;
      chk(cyc - t2, 70);
      if (tp5n == 0) chk(regBus, expW1);
    end
    if (timingPulse[3] === 1'b1) begin
      t4 <= cyc;
      chk(cyc - t3, 60);
      chk(adderSelect, 1'(tp5n == 1));
      chk(regBus, (tp5n == 1) ? expSum : 12'h000);
    end
    if (timingPulse[4] === 1'b1) begin
      tp5n <= tp5n + 1;
      chk(cyc - t4, 80);
    end
    if (memStart === 1'b1) mcount <= mcount + 1;
  end
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    tp5n <= 0;
    mcount <= 0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] exp_status(logic alt, iac_word_t acc, iac_word_t w1, iac_word_t w2, logic idx);
    logic [12:0] s;
    iac_word_t mb;
    s = {1'b0, acc} + {1'b0, w2};
    mb = w1 + {11'h0, idx};
    return {29'h0, alt, alt & mb[11], s[12]};
  endfunction
  // One defer plus execute pass of the indexed add
  task automatic run(input iac_word_t acc, input iac_word_t w1, input iac_word_t w2, input logic idx,
                     input logic alt);
    int n;
    iac_word_t mb;
    do_reset();
    if (alt) bus(1'b1, `IAC_OFS_CTRL, 32'h0000_0180, q);
    bus(1'b1, `IAC_OFS_ACC, {20'h0, acc}, q);
    expW1 = w1;
    expSum = acc + w2;
    nextWord <= w1;
    bus(1'b1, `IAC_OFS_CTRL, {24'h0, alt, 2'b00, idx, 4'b1101}, q);
    n = 0;
    while (mcount < 1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    nextWord <= w2;
    while (tp5n < 2 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) failures++;
    repeat (3) @(posedge clk);
    chk(mcount, 2);
    mb = w1 + {11'h0, idx};
    bus(1'b0, `IAC_OFS_MADDR, 0, q);
    chk(q, {20'h0, mb & (idx ? 12'h3FF : 12'h07F)});
    chk(memAddress, mb & (idx ? 12'h3FF : 12'h07F));
    bus(1'b0, `IAC_OFS_ACC, 0, q);
    chk(q, {20'h0, acc + w2});
    bus(1'b0, `IAC_OFS_MBUF, 0, q);
    chk(q, {20'h0, w2});
    bus(1'b0, `IAC_OFS_STATUS, 0, q);
    chk(q >> 9, exp_status(alt, acc, w1, w2, idx));
    if (alt) begin
      bus(1'b1, `IAC_OFS_CTRL, 32'h0000_0200, q);
      bus(1'b0, `IAC_OFS_STATUS, 0, q);
      chk(q[11], 1'b0);
    end
  endtask
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    nextWord = '0;
    void'($urandom(57));
    do_reset();
    chk(timeState, 5'h01);
    bus(1'b0, `IAC_OFS_STATUS, 0, q);
    chk(q, 32'h0000_0081);
    bus(1'b0, 5'h14, 0, q);
    chk(q, 32'h0000_0000);
    // Enable low stalls the slave; the read finishes once it returns
    clkEn <= 1'b0;
    fork
      bus(1'b0, `IAC_OFS_STATUS, 0, q);
      begin
        repeat (6) @(posedge clk);
        chk(avs_waitrequest, 1'b1);
        clkEn <= 1'b1;
      end
    join
    chk(q, 32'h0000_0081);
    // Corner cases: adder carry out, carry insert wrap, marker with adder carry out
    run(12'hFFF, 12'h123, 12'h001, 1'b0, 1'b0);
    run(12'h000, 12'hFFF, 12'hFFF, 1'b1, 1'b1);
    run(12'h7FF, 12'h800, 12'h801, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run(12'($urandom), 12'($urandom), 12'($urandom), 1'($urandom), 1'($urandom));
    end
    give_verdict();
  end
endmodule // indexed_add_cycle_sequencer_tb
`default_nettype wire
